// [core/freq_ctrl_dac_sequencer.sv]
// Frequency control sequencer driving a 13-bit oscillator control converter.
// Assumes timer event inputs come from logic on clk_sys and register bus is
// a simple single-cycle select/write/read peripheral port.
// Notes on behaviour
// - Converter sample is thirteen bits wide
// - Event-valid strobe copies write buffers to active, save a slot written to active that cycle
// - Event pulse i loads active buffer i out
// - Converter always on or on for period
// - Immediate mode writes reach output at once
// - Leaving immediate mode keeps period, events restart it
// - Read-active bit selects active buffer for reads
// - Write-active bit selects active buffer for writes
// - Force-power bit keeps converter always powered
// - Immediate mode uses value zero write buffer only
// - Output buffer is zero until first update
// - Period field is thirteen bits, 0 to 8191
// - Either mode bit ignores period, stays powered
// - Neither bit: power for programmed period
// - Period resets to 255
module freq_ctrl_dac_sequencer #(
   parameter int unsigned QBIT_CYCLES = freq_ctrl_pkg::QBIT_CYCLES
) (
   input  wire logic        clk_sys,          // System clock, 100 MHz
   input  wire logic        rst_n,            // Asynchronous reset, active low
   input  wire logic        bus_sel,          // Register access request
   input  wire logic        bus_write,        // 1 write, 0 read
   input  wire logic [7:0]  bus_addr,         // Byte address
   input  wire logic [15:0] bus_wdata,        // Write data
   output logic      [15:0] bus_rdata,        // Read data, registered
   output logic             bus_ready,        // Access done pulse
   input  wire logic        event_valid_strobe, // Copy write to active buffers
   input  wire logic [3:0]  freq_event_pulse, // One-hot event per index
   output logic      [12:0] dac_sample,       // Converter sample
   output logic             converter_awake   // Converter powered, high
);
   localparam int unsigned N = freq_ctrl_pkg::NUM_VALUES;

   logic [3:0]  config_reg;
   logic [12:0] period_reg;
   logic [12:0] wr_buf [N];                    // No reset on purpose
   logic [12:0] act_buf [N];
   logic [12:0] sample_reg;
   logic [12:0] sample_next;
   logic [12:0] count_reg;
   logic [12:0] count_next;
   logic [15:0] tick_reg;
   logic        awake_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic        ready_reg;

   // Decode value register index; returns N when not a value register
   function automatic logic [2:0] value_index(input logic [7:0] a);
      logic [2:0] idx;
      idx = 3'(N);
      case (a)
         freq_ctrl_pkg::OFS_VALUE_0: idx = 3'h0;
         freq_ctrl_pkg::OFS_VALUE_1: idx = 3'h1;
         freq_ctrl_pkg::OFS_VALUE_2: idx = 3'h2;
         freq_ctrl_pkg::OFS_VALUE_3: idx = 3'h3;
         default:                    idx = 3'(N);
      endcase
      return idx;
   endfunction

   // One-hot slot mask from a value index; zero when no value register is hit
   function automatic logic [3:0] slot_onehot(input logic [2:0] idx);
      logic [3:0] hot;
      hot = 4'h0;
      case (idx)
         3'h0:    hot = 4'h1;
         3'h1:    hot = 4'h2;
         3'h2:    hot = 4'h4;
         3'h3:    hot = 4'h8;
         default: hot = 4'h0;
      endcase
      return hot;
   endfunction

   // Bus decode
   wire         wr_en       = bus_sel & bus_write;
   wire         rd_en       = bus_sel & ~bus_write;
   wire [2:0]   vidx        = value_index(bus_addr);
   wire         hit_value   = (vidx != 3'(N));
   wire         wr_config   = wr_en & (bus_addr == freq_ctrl_pkg::OFS_CONFIG);
   wire         wr_period   = wr_en & (bus_addr == freq_ctrl_pkg::OFS_PERIOD);

   // Mode bits, decoded once for every consumer
   wire         immediate   = config_reg[freq_ctrl_pkg::BIT_IMMEDIATE];
   wire         wr_active   = config_reg[freq_ctrl_pkg::BIT_WR_ACTIVE];
   wire         force_pu    = config_reg[freq_ctrl_pkg::BIT_FORCE_PU];
   wire         rd_active   = config_reg[freq_ctrl_pkg::BIT_RD_ACTIVE];
   wire         wr_value    = wr_en & hit_value;
   wire         wr_to_act   = wr_value & wr_active;
   wire         wr_to_wbuf  = wr_value & ~wr_active;
   wire [3:0]   slot_hot    = slot_onehot(vidx);
   wire [3:0]   wbuf_hit    = {4{wr_to_wbuf}} & slot_hot;
   wire [3:0]   act_hit     = {4{wr_to_act}} & slot_hot;
   wire [1:0]   vsel        = vidx[1:0];
   wire [12:0]  wdata13     = bus_wdata[12:0];

   // Converter power; either mode bit pins it on whatever the period says
   wire         always_on   = immediate | force_pu;
   wire         any_event   = |freq_event_pulse;
   wire         tick        = (tick_reg == 16'(QBIT_CYCLES - 1));
   wire         awake_next  = always_on | (count_next != 13'h0000);

   // Read mux; unmapped reads return zero
   wire [12:0]  val_rd      = rd_active ? act_buf[vsel] : wr_buf[vsel];
   always_comb
   begin
      rdata_next = 16'h0000;
      if (rd_en)
      begin
         case (bus_addr)
            freq_ctrl_pkg::OFS_CONFIG:
            begin
               rdata_next = {12'h000, config_reg};
            end
            freq_ctrl_pkg::OFS_PERIOD:
            begin
               rdata_next = {3'h0, period_reg};
            end
            freq_ctrl_pkg::OFS_VALUE_0,
            freq_ctrl_pkg::OFS_VALUE_1,
            freq_ctrl_pkg::OFS_VALUE_2,
            freq_ctrl_pkg::OFS_VALUE_3:
            begin
               rdata_next = {3'h0, val_rd};
            end
            default:
            begin
               rdata_next = 16'h0000;
            end
         endcase
      end
   end

   // Output sample selection; lowest index wins if the timer breaks the one-hot
   // promise, and immediate mode ignores timer events entirely
   always_comb
   begin
      sample_next = sample_reg;
      if (immediate)
      begin
         sample_next = wr_buf[0];
      end
      else if (freq_event_pulse[0])
      begin
         sample_next = act_buf[0];
      end
      else if (freq_event_pulse[1])
      begin
         sample_next = act_buf[1];
      end
      else if (freq_event_pulse[2])
      begin
         sample_next = act_buf[2];
      end
      else if (freq_event_pulse[3])
      begin
         sample_next = act_buf[3];
      end
   end

   // Period counter: reload on event, else count down on quarter-bit ticks.
   // Leaving immediate mode with always-on reloads so the converter stays up.
   always_comb
   begin
      count_next = count_reg;
      if (always_on)
      begin
         count_next = period_reg;
      end
      else if (any_event)
      begin
         count_next = period_reg;
      end
      else if (tick && count_reg != 13'h0000)
      begin
         count_next = count_reg - 13'h0001;
      end
   end

   // Control register; immediate alone keeps the converter powered, force power not needed
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         config_reg <= freq_ctrl_pkg::CONFIG_RST;
      end
      else if (wr_config)
      begin
         config_reg <= bus_wdata[freq_ctrl_pkg::CONFIG_W-1:0];
      end
   end

   // Power-up period; the full 13-bit range is accepted
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         period_reg <= freq_ctrl_pkg::PERIOD_RST;
      end
      else if (wr_period)
      begin
         period_reg <= bus_wdata[12:0];
      end
   end

   // Value slot 0; no reset on purpose. A direct active write beats the
   // strobe copy of the same slot so software data is not overwritten
   always_ff @(posedge clk_sys)
   begin
      if (wbuf_hit[0])
         wr_buf[0] <= wdata13;
      if (act_hit[0])
         act_buf[0] <= wdata13;
      else if (event_valid_strobe)
         act_buf[0] <= wr_buf[0];
   end

   // Value slot 1
   always_ff @(posedge clk_sys)
   begin
      if (wbuf_hit[1])
         wr_buf[1] <= wdata13;
      if (act_hit[1])
         act_buf[1] <= wdata13;
      else if (event_valid_strobe)
         act_buf[1] <= wr_buf[1];
   end

   // Value slot 2
   always_ff @(posedge clk_sys)
   begin
      if (wbuf_hit[2])
         wr_buf[2] <= wdata13;
      if (act_hit[2])
         act_buf[2] <= wdata13;
      else if (event_valid_strobe)
         act_buf[2] <= wr_buf[2];
   end

   // Value slot 3
   always_ff @(posedge clk_sys)
   begin
      if (wbuf_hit[3])
         wr_buf[3] <= wdata13;
      if (act_hit[3])
         act_buf[3] <= wdata13;
      else if (event_valid_strobe)
         act_buf[3] <= wr_buf[3];
   end

   // Quarter-bit tick divider; free running, so the first tick after an
   // event lands anywhere within one quarter bit
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_reg <= 16'h0000;
      end
      else if (tick)
      begin
         tick_reg <= 16'h0000;
      end
      else
      begin
         tick_reg <= tick_reg + 16'h0001;
      end
   end

   // Output buffer
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         sample_reg <= freq_ctrl_pkg::SAMPLE_RST;
      else
         sample_reg <= sample_next;
   end

   // Power-up down-counter
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         count_reg <= 13'h0000;
      else
         count_reg <= count_next;
   end

   // Converter power, registered so the pin never glitches
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         awake_reg <= 1'b0;
      else
         awake_reg <= awake_next;
   end

   // Bus read data, one cycle after the request
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rdata_reg <= 16'h0000;
      else
         rdata_reg <= rdata_next;
   end

   // Bus answer strobe; every access is answered, none is refused
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         ready_reg <= 1'b0;
      else
         ready_reg <= bus_sel;
   end

   assign dac_sample      = sample_reg;
   assign converter_awake = awake_reg;
   assign bus_rdata       = rdata_reg;
   assign bus_ready       = ready_reg;
endmodule

// [inc/freq_ctrl_pkg.sv]
// Package for the frequency control converter sequencer.
// Assumes a peripheral word bus with byte addresses and 16-bit data in the low bits.
package freq_ctrl_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned SAMPLE_W      = 13;
   localparam int unsigned NUM_VALUES    = 4;
   // Register byte offsets
   localparam logic [7:0]  OFS_CONFIG    = 8'h00;
   localparam logic [7:0]  OFS_VALUE_0   = 8'h04;
   localparam logic [7:0]  OFS_VALUE_1   = 8'h08;
   localparam logic [7:0]  OFS_VALUE_2   = 8'h0C;
   localparam logic [7:0]  OFS_VALUE_3   = 8'h10;
   localparam logic [7:0]  OFS_PERIOD    = 8'h14;
   // Config field positions
   localparam int unsigned BIT_IMMEDIATE = 0;
   localparam int unsigned BIT_WR_ACTIVE = 1;
   localparam int unsigned BIT_FORCE_PU  = 2;
   localparam int unsigned BIT_RD_ACTIVE = 3;
   localparam int unsigned CONFIG_W      = 4;
   // Reset values
   localparam logic [3:0]  CONFIG_RST    = 4'h0;
   localparam logic [12:0] PERIOD_RST    = 13'h00FF;
   localparam logic [12:0] SAMPLE_RST    = 13'h0000;
   // Quarter-bit tick: 48/13 us per quarter bit, about 3692.3 ns
   localparam int unsigned QBIT_NS_NUM   = 48000;
   localparam int unsigned QBIT_NS_DEN   = 13;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned QBIT_CYCLES   = QBIT_NS_NUM / (QBIT_NS_DEN * CLK_PERIOD_NS);
endpackage

// [dv/freq_ctrl_props.sv]
// Port checker for the frequency control sequencer.
// Assumes a bind by name from the bench top file.
module freq_ctrl_props (
   input wire logic        clk_sys,            // Clock
   input wire logic        rst_n,              // Reset, low
   input wire logic        bus_sel,            // Request
   input wire logic        bus_write,          // Write
   input wire logic [7:0]  bus_addr,           // Address
   input wire logic [15:0] bus_wdata,          // Write data
   input wire logic [15:0] bus_rdata,          // Read data
   input wire logic        bus_ready,          // Done
   input wire logic        event_valid_strobe, // Copy
   input wire logic [3:0]  freq_event_pulse,   // Events
   input wire logic [12:0] dac_sample,         // Sample
   input wire logic        converter_awake     // Power
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  cfg_reg;
   logic [12:0] per_reg;
   wire         wr_go   = bus_sel && bus_write;
   wire         on_mode = cfg_reg[0] || cfg_reg[2];
   // Shadow copies, so the power rules can be judged from the ports alone
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
      begin
         cfg_reg <= 4'h0;
         per_reg <= 13'h00FF;
      end
      else if (wr_go && bus_addr == freq_ctrl_pkg::OFS_CONFIG)
         cfg_reg <= bus_wdata[3:0];
      else if (wr_go && bus_addr == freq_ctrl_pkg::OFS_PERIOD)
         per_reg <= bus_wdata[12:0];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence ev_s;
      freq_event_pulse != 4'h0 && !cfg_reg[0] && per_reg != 13'h0000;
   endsequence
   sequence imm_wr_s;
      wr_go && bus_addr == freq_ctrl_pkg::OFS_VALUE_0 && cfg_reg == 4'h5;
   endsequence
   ready_after_sel_a: assert property (bus_sel |=> bus_ready)
      else $error("no ready after request");
   ready_cause_a: assert property (bus_ready |-> $past(bus_sel))
      else $error("ready without request");
   write_rdata_a: assert property (wr_go |=> bus_rdata == 16'h0000)
      else $error("write returned data");
   period_read_a: assert property (bus_sel && !bus_write && bus_addr == 8'h14
      |=> bus_rdata == {3'h0, $past(per_reg)}) else $error("period readback wrong");
   always_on_a: assert property (on_mode |=> converter_awake)
      else $error("converter asleep while forced");
   event_wake_a: assert property (ev_s |=> converter_awake)
      else $error("event did not wake converter");
   imm_follow_a: assert property (imm_wr_s |-> ##2 dac_sample == $past(bus_wdata[12:0], 2))
      else $error("immediate value not on output");
   dac_cause_a: assert property ($changed(dac_sample)
      |-> $past(freq_event_pulse) != 4'h0 || $past(cfg_reg[0])) else $error("sample moved");
   sleep_cause_a: assert property ($fell(converter_awake) |-> !$past(on_mode))
      else $error("converter slept while forced");
endmodule

// [dv/timer_event_model.sv]
// Frame timer stand-in issuing copy strobes and indexed events.
// Assumes the bench asks for one event at a time on clk_sys.
module timer_event_model #(parameter int FRAME = 8) (
   input wire logic       clk_sys,            // Clock
   input wire logic       fire,               // Event request
   input wire logic [1:0] fire_idx,           // Event index
   input wire logic       copy,               // Strobe request
   output logic           event_valid_strobe, // Buffer copy
   output logic [3:0]     freq_event_pulse    // One-hot event
);
   timeunit 1ns;
   timeprecision 1ps;
   int tick = 0;
   int used = 0;
   initial
   begin
      event_valid_strobe = 1'b0;
      freq_event_pulse = 4'h0;
   end
   // A fifth event inside one frame is swallowed, as the real timer never sends it
   always @(posedge clk_sys)
   begin
      tick <= (tick == FRAME - 1) ? 0 : tick + 1;
      used <= (tick == FRAME - 1) ? 0 : used + int'(fire);
      freq_event_pulse <= (fire && used < 4) ? 4'h1 << fire_idx : 4'h0;
      event_valid_strobe <= copy;
   end
endmodule

// [dv/freq_ctrl_dac_sequencer_test.sv]
// Self-checking bench for the frequency control sequencer.
// Assumes the checker and the timer model are compiled before it.
module freq_ctrl_dac_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int Q = 4;
   localparam int P = 3;
   logic clk_sys = 1'b0, rst_n = 1'b0, bus_sel = 1'b0, bus_write = 1'b0, fire = 1'b0;
   logic copy = 1'b0, bus_ready, event_valid_strobe, converter_awake;
   logic [1:0] fire_idx = 2'h0;
   logic [3:0] freq_event_pulse;
   logic [7:0] bus_addr = 8'h00;
   logic [12:0] dac_sample, v, wb [4], ab [4];
   logic [15:0] bus_wdata = 16'h0000, bus_rdata, rd;
   int fail_count = 0, samples_checked = 0, n;
   freq_ctrl_dac_sequencer #(.QBIT_CYCLES(Q)) u_dut (.clk_sys, .rst_n, .bus_sel, .bus_write,
      .bus_addr, .bus_wdata, .bus_rdata, .bus_ready, .event_valid_strobe, .freq_event_pulse,
      .dac_sample, .converter_awake);
   timer_event_model u_timer (.clk_sys, .fire, .fire_idx, .copy, .event_valid_strobe,
      .freq_event_pulse);
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end
   function automatic logic in_win(input int c);
      return c >= (P - 1) * Q - 2 && c <= P * Q + 1;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Select is a one-cycle pulse; the answer is looked at mid-cycle, once settled
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bus_sel <= 1'b1;
      bus_write <= w;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk_sys);
      bus_sel <= 1'b0;
      @(negedge clk_sys);
      rd = bus_rdata;
   endtask
   task automatic ev(input int i, input logic c);
      @(posedge clk_sys);
      fire <= !c;
      copy <= c;
      fire_idx <= 2'(i);
      @(posedge clk_sys);
      fire <= 1'b0;
      copy <= 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic sweep(input logic r, input logic d);
      for (int i = 0; i < 4; i++)
      begin
         bus(0, 8'(4 + 4 * i), 0);
         check(rd, {3'h0, r ? ab[i] : wb[i]});
         ev(i, 0);
         check({3'h0, dac_sample}, {3'h0, d ? ab[i] : wb[i]});
      end
   endtask
   task automatic win;
      n = 0;
      while (converter_awake === 1'b1 && n < 100)
      begin
         @(negedge clk_sys);
         n++;
      end
      check({15'h0, in_win(n)}, 16'h0001);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #50000;
      fail_count++;
      print_verdict;
   end
   initial
   begin
      v = 13'($urandom(32'h2908));
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      bus(0, freq_ctrl_pkg::OFS_PERIOD, 0);
      check(rd, 16'h00FF);
      bus(1, 8'h18, 16'hFFFF);
      bus(0, 8'h18, 0);
      check(rd | {3'h0, dac_sample}, 16'h0000);
      bus(1, freq_ctrl_pkg::OFS_PERIOD, 16'hFFFF);
      bus(0, freq_ctrl_pkg::OFS_PERIOD, 0);
      check(rd, 16'h1FFF);
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         wb[i] = 13'($urandom);
         ab[i] = ~wb[i];
         bus(1, 8'(4 + 4 * i), {3'h0, wb[i]});
      end
      bus(1, 0, 16'h0002);
      for (int i = 0; i < 4; i++) bus(1, 8'(4 + 4 * i), {3'h0, ab[i]});
      bus(1, 0, 16'h0000);
      sweep(0, 1);
      bus(1, 0, 16'h0008);
      sweep(1, 1);
      ev(0, 1);
      sweep(0, 0);
      $display("test buffers done");
      bus(1, freq_ctrl_pkg::OFS_PERIOD, 16'(P));
      ev(1, 0);
      win;
      bus(1, freq_ctrl_pkg::OFS_PERIOD, 0);
      ev(2, 0);
      check({15'h0, converter_awake}, 16'h0000);
      bus(1, 0, 16'h0004);
      repeat (30) @(negedge clk_sys);
      check({15'h0, converter_awake}, 16'h0001);
      $display("test power done");
      bus(1, freq_ctrl_pkg::OFS_PERIOD, 16'(P));
      bus(1, 8'h04, {3'h0, v});
      bus(1, 0, 16'h0005);
      @(negedge clk_sys);
      check({3'h0, dac_sample}, {3'h0, v});
      v = ~v;
      bus(1, 8'h04, {3'h0, v});
      ev(3, 0);
      check({3'h0, dac_sample}, {3'h0, v});
      bus(1, 0, 16'h0000);
      win;
      $display("test immediate done");
      print_verdict;
   end
endmodule
bind freq_ctrl_dac_sequencer freq_ctrl_props u_props (.clk_sys, .rst_n, .bus_sel,
   .bus_write, .bus_addr, .bus_wdata, .bus_rdata, .bus_ready, .event_valid_strobe,
   .freq_event_pulse, .dac_sample, .converter_awake);
